// >>> hw/gp_defs.svh
// Register offsets, field positions, reset values and pin map of the I/O port block
`ifndef GP_DEFS_SVH
`define GP_DEFS_SVH
`define GP_ADDR_W 12
`define GP_OFS_DIR 4'h0
`define GP_OFS_PIN 4'h4
`define GP_OFS_LAT 4'h8
`define GP_ADDR_ICR2 12'h100
`define GP_DIR_RST 8'hff
`define GP_LAT_RST 8'h00
`define GP_ICR2_RST 8'h00
`define GP_PUG_RST 3'h0
`define GP_PORT_B 4'h1
`define GP_PORT_D 4'h3
`define GP_PORT_E 4'h4
`define GP_PORT_G 4'h6
`define GP_PORT_J 4'h8
`define GP_PU_B_BIT 7
`define GP_G_CTL_LSB 5
`define GP_PU_D_BIT 2
`define GP_PU_E_BIT 1
`define GP_PU_J_BIT 0
`define GP_OD_SER1 3'h1
`define GP_OD_SER2 3'h2
`define GP_OD_SPI 3'h3
`define GP_OD_CCP1 3'h4
`define GP_OD_CCP2 3'h5
`define GP_OD_CCP2B 3'h6
`endif

// >>> hw/gp_pkg.sv
// Types shared by the I/O port block
package gp_pkg;
  typedef enum logic [1:0] {
    GP_IDLE = 2'b01,
    GP_RESP = 2'b10
  } gp_state_t;
  typedef enum logic [1:0] {
    GP_K_DIR = 2'h0,
    GP_K_PIN = 2'h1,
    GP_K_LAT = 2'h2,
    GP_K_ICR2 = 2'h3
  } gp_kind_t;
  typedef struct packed {
    logic hit;
    gp_kind_t kind;
    logic [3:0] port;
  } gp_dec_t;
endpackage

// >>> hw/gp_port.sv
// General purpose I/O ports with Avalon-MM register access
// Notes on behaviour
// [R1] Up to nine ports, three registers each
// [R2] Pin read gives levels; pin write sets latch
// [R3] Direction 1 makes pin high impedance input
// [R4] Direction 0 drives pin from latch bit
// [R5] Latch register reads back latched value
// [R6] Enabled peripheral takes over its pin
// [R7] Pull-ups: B via control bit, D/E/J via G
// [R8] Open-drain bits per module in G registers
// [R9] Open-drain: drive low for 0, release for 1
`timescale 1ns/1ns
`default_nettype none
`include "gp_defs.svh"
module gp_port
  import gp_pkg::*;
#(
  parameter int NPORTS = 9,
  parameter int W = 8
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [`GP_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [NPORTS*W-1:0] pin_in,
  output logic [NPORTS*W-1:0] pin_out,
  output logic [NPORTS*W-1:0] pin_oe_n,
  output logic [NPORTS*W-1:0] pin_pu,
  input wire logic [NPORTS*W-1:0] periph_en,
  input wire logic [NPORTS*W-1:0] periph_drive,
  input wire logic [NPORTS*W-1:0] periph_out
);
  localparam int NPIN = NPORTS * W;

  function automatic gp_dec_t gp_dec(input logic [`GP_ADDR_W-1:0] a);
    gp_dec_t r;
    r.hit = 1'b0;
    r.kind = GP_K_DIR;
    r.port = a[7:4];
    if (a == `GP_ADDR_ICR2)
    begin
      r.hit = 1'b1;
      r.kind = GP_K_ICR2;
    end
    else if (a[11:8] == 4'h0 && int'(a[7:4]) < NPORTS)
    begin
      r.hit = (a[3:0] == `GP_OFS_DIR) || (a[3:0] == `GP_OFS_PIN) || (a[3:0] == `GP_OFS_LAT);
      r.kind = (a[3:0] == `GP_OFS_PIN) ? GP_K_PIN : (a[3:0] == `GP_OFS_LAT) ? GP_K_LAT : GP_K_DIR;
    end
    return r;
  endfunction

  // Module owning the open-drain option of a pin, 0 for none
  function automatic logic [2:0] od_mod(input int i);
    case (i)
      22, 23: return `GP_OD_SER1;
      49, 50: return `GP_OD_SER2;
      19, 21: return `GP_OD_SPI;
      18: return `GP_OD_CCP1;
      17: return `GP_OD_CCP2;
      39: return `GP_OD_CCP2B;
      default: return 3'h0;
    endcase
  endfunction

  gp_state_t st_q, st_d;
  logic [NPORTS-1:0][W-1:0] dir_q, dir_d, lat_q, lat_d;
  logic [7:0] icr2_q, icr2_d;
  logic [2:0] pug_q, pug_d;
  logic [31:0] rdata_q, rdata_d;
  logic [NPIN-1:0] out_d, oe_n_d, pu_d, out_q, oe_n_q, pu_q;
  logic [NPIN-1:0] dir_v, lat_v, drv_v, val_v, od_v, ok_v;
  logic [5:0] od_ctl;
  gp_dec_t dq;
  logic [W-1:0] rd_mux;

  assign dq = gp_dec(address);
  assign dir_v = dir_q;
  assign lat_v = lat_q;
  // Upper bits of G direction and latch hold open-drain controls
  assign od_ctl = {lat_q[`GP_PORT_G][7:5], dir_q[`GP_PORT_G][7:5]}; // [R8]
  assign waitrequest = !(st_q == GP_RESP && ce);
  assign readdata = rdata_q;
  assign pin_out = out_q;
  assign pin_oe_n = oe_n_q;
  assign pin_pu = pu_q;

  always_comb
  begin
    rd_mux = 8'h00;
    if (dq.hit)
    begin
      unique case (dq.kind)
        GP_K_DIR: rd_mux = dir_q[dq.port];
        GP_K_LAT: rd_mux = lat_q[dq.port]; // [R5]
        GP_K_ICR2: rd_mux = icr2_q;
        GP_K_PIN:
        begin
          rd_mux = pin_in[dq.port*W +: W]; // [R2]
          if (dq.port == `GP_PORT_G)
            rd_mux[7:5] = pug_q; // [R7]
        end
      endcase
    end
  end

  always_comb
  begin
    st_d = st_q;
    dir_d = dir_q;
    lat_d = lat_q;
    icr2_d = icr2_q;
    pug_d = pug_q;
    rdata_d = rdata_q;
    unique case (st_q)
      GP_IDLE:
      begin
        if (read || write)
          st_d = GP_RESP;
        if (read)
          rdata_d = {24'h000000, rd_mux}; // [R1]
      end
      GP_RESP:
      begin
        st_d = GP_IDLE;
        if (write && dq.hit)
        begin
          unique case (dq.kind)
            GP_K_DIR: dir_d[dq.port] = writedata[7:0];
            GP_K_LAT: lat_d[dq.port] = writedata[7:0]; // [R5]
            GP_K_ICR2: icr2_d = writedata[7:0];
            GP_K_PIN:
            begin
              lat_d[dq.port] = writedata[7:0]; // [R2]
              if (dq.port == `GP_PORT_G)
                pug_d = writedata[7:5]; // [R7]
            end
          endcase
        end
      end
      default: st_d = GP_IDLE;
    endcase
  end

  always_comb
  begin
    logic [2:0] m;
    logic pe;
    m = 3'h0;
    pe = 1'b0;
    for (int i = 0; i < NPIN; i++)
    begin
      m = od_mod(i);
      // Enabled peripheral overrides direction and latch
      drv_v[i] = periph_en[i] ? periph_drive[i] : ~dir_v[i]; // [R3] [R4] [R6]
      val_v[i] = periph_en[i] ? periph_out[i] : lat_v[i]; // [R6]
      od_v[i] = (m != 3'h0) && od_ctl[m - 3'h1]; // [R8]
      // Pins G5..G7 are control bits, not pins
      ok_v[i] = !((i / W) == int'(`GP_PORT_G) && (i % W) >= `GP_G_CTL_LSB);
      out_d[i] = od_v[i] ? 1'b0 : val_v[i]; // [R9]
      oe_n_d[i] = !(ok_v[i] && drv_v[i] && !(od_v[i] && val_v[i])); // [R3] [R9]
      case (i / W)
        int'(`GP_PORT_B): pe = icr2_q[`GP_PU_B_BIT];
        int'(`GP_PORT_D): pe = pug_q[`GP_PU_D_BIT];
        int'(`GP_PORT_E): pe = pug_q[`GP_PU_E_BIT];
        int'(`GP_PORT_J): pe = pug_q[`GP_PU_J_BIT];
        default: pe = 1'b0;
      endcase
      pu_d[i] = pe && !(ok_v[i] && drv_v[i]); // [R7]
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= GP_IDLE;
      dir_q <= {NPORTS{`GP_DIR_RST}};
      lat_q <= {NPORTS{`GP_LAT_RST}};
      icr2_q <= `GP_ICR2_RST;
      pug_q <= `GP_PUG_RST;
      rdata_q <= 32'h00000000;
      out_q <= '0;
      oe_n_q <= '1;
      pu_q <= '0;
    end
    else if (ce)
    begin
      st_q <= st_d;
      dir_q <= dir_d;
      lat_q <= lat_d;
      icr2_q <= icr2_d;
      pug_q <= pug_d;
      rdata_q <= rdata_d;
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      pu_q <= pu_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_bus_one_wait: assert property ( // [R1]
    (st_q == GP_IDLE && (read || write) && ce) |=> (st_q == GP_RESP) ##0 (!ce || !waitrequest))
    else $error("request not answered after one wait cycle");
  a_unmapped_zero: assert property ( // [R1]
    (st_q == GP_IDLE && read && ce && address == 12'h0f0) |=> (readdata == 32'h00000000))
    else $error("unmapped read not zero");
  a_pin_read: assert property ( // [R2]
    (st_q == GP_IDLE && read && ce && address == 12'h004) |=> (readdata[7:0] == $past(pin_in[7:0])))
    else $error("pin read does not show pin levels");
  a_pin_write_lat: assert property ( // [R2]
    (!waitrequest && write && address == 12'h004) |=> (lat_q[0] == $past(writedata[7:0])))
    else $error("pin write did not reach latch");
  a_lat_readback: assert property ( // [R5]
    (st_q == GP_IDLE && read && ce && address == 12'h008) |=> (readdata[7:0] == $past(lat_q[0])))
    else $error("latch read not latched value");
  a_input_hiz: assert property ( // [R3]
    ce |=> ((~oe_n_q & $past(dir_v & ~periph_en)) == '0))
    else $error("input pin is driven");
  a_output_drive: assert property ( // [R4]
    ce |=> (((oe_n_q | (out_q ^ $past(lat_v))) & $past(~dir_v & ~periph_en & ~od_v & ok_v))
      == '0))
    else $error("output pin not driven from latch");
  a_periph_owns: assert property ( // [R6]
    ce |=> (((out_q ^ $past(periph_out)) & $past(periph_en & ~od_v)) == '0))
    else $error("peripheral value not on pin");
  a_od_release: assert property ( // [R8] [R9]
    ce |=> ((((oe_n_q ^ $past(val_v)) | out_q) & $past(od_v & drv_v & ok_v)) == '0))
    else $error("open-drain pin misdriven");
  a_pullup_b: assert property ( // [R7]
    ce |=> (pu_q[15:8] == $past({8{icr2_q[7]}} & ~drv_v[15:8])))
    else $error("port B pull-up wrong");
  a_ce_freeze: assert property ( // [R1]
    !ce |=> $stable(dir_q) && $stable(lat_q) && $stable(oe_n_q))
    else $error("state moved with clock enable low");

  c_dir_write: cover property (!waitrequest && write && address == 12'h000);
  c_od_low: cover property (ce && |(od_v & drv_v & ~val_v));
  c_periph_take: cover property (ce && |(periph_en & periph_drive));
  c_pull_on: cover property (|pu_q);
endmodule
`default_nettype wire

// >>> dv/gp_pin_world.sv
// Model of the circuits wired to the port pins
`timescale 1ns/1ns
`default_nettype none
module gp_pin_world #(
  parameter int N = 72
)(
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe_n,
  input wire logic [N-1:0] pin_pu,
  input wire logic [N-1:0] ext_en,
  input wire logic [N-1:0] ext_val,
  input wire logic [N-1:0] ext_pu,
  output logic [N-1:0] pin_in
);
  // Pad first, then outside driver, then pull-ups, else inverse of last value
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ((ext_en & ext_val) |
    (~ext_en & (pin_pu | ext_pu | ~pin_out))));
endmodule
`default_nettype wire

// >>> dv/test_gp_port.sv
// Self-checking bench for the I/O port block
`timescale 1ns/1ns
`default_nettype none
`include "gp_defs.svh"
module test_gp_port;
  import gp_pkg::*;
  logic clk = 0, rstn = 0, read = 0, write = 0, waitrequest;
  logic ce = 1;
  logic [11:0] address = '0;
  logic [31:0] writedata = '0, readdata;
  logic [71:0] pin_in, pin_out, pin_oe_n, pin_pu;
  logic [71:0] pen = '0, pdrv = '0, pout = '0, ext_en = '0, ext_val = '0, ext_pu = '0;
  logic [7:0] q;
  int bad_count = 0, cmp_count = 0;
  always #5 clk = ~clk;
  gp_port i_dut (.clk(clk), .rstn(rstn), .ce(ce), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pu(pin_pu),
    .periph_en(pen), .periph_drive(pdrv), .periph_out(pout));
  gp_pin_world i_world (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pu(pin_pu),
    .ext_en(ext_en), .ext_val(ext_val), .ext_pu(ext_pu), .pin_in(pin_in));
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon transfer; w=0 reads into q
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    read <= !w;
    write <= w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0)
    begin
      bad_count++;
      stop_test;
    end
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    for (int p = 0; p < 9; p++)
    begin
      bus(0, 12'(p * 16), 8'h00);
      chk(q, `GP_DIR_RST);
      bus(0, 12'(p * 16 + 8), 8'h00);
      chk(q, `GP_LAT_RST);
    end
    chk(8'(&pin_oe_n), 8'h01);
    bus(0, 12'h00c, 8'h00);
    chk(q, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_out;
    bus(1, 12'h000, 8'h00);
    bus(1, 12'h004, 8'h5a);
    bus(0, 12'h008, 8'h00);
    chk(q, 8'h5a);
    settle;
    chk(pin_oe_n[7:0], 8'h00);
    chk(pin_out[7:0], 8'h5a);
    bus(1, 12'h000, 8'hff);
    ext_en[7:0] <= 8'hff;
    ext_val[7:0] <= 8'ha5;
    settle;
    chk(pin_oe_n[7:0], 8'hff);
    bus(0, 12'h004, 8'h00);
    chk(q, 8'ha5);
    bus(0, 12'h008, 8'h00);
    chk(q, 8'h5a);
    $display("output test done");
  endtask
  task automatic t_periph;
    pen[0] <= 1'b1;
    pdrv[0] <= 1'b1;
    pout[0] <= 1'b1;
    settle;
    chk(8'({pin_oe_n[0], pin_out[0]}), 8'h01);
    @(posedge clk);
    pen[0] <= 1'b0;
    $display("peripheral test done");
  endtask
  task automatic t_ce;
    bus(1, 12'h000, 8'h00);
    @(posedge clk);
    ce <= 1'b0;
    pen[7:0] <= 8'hff;
    pdrv[7:0] <= 8'hff;
    pout[7:0] <= 8'h00;
    settle;
    chk(pin_out[7:0], 8'h5a);
    @(posedge clk);
    ce <= 1'b1;
    settle;
    chk(pin_out[7:0], 8'h00);
    @(posedge clk);
    pen[7:0] <= 8'h00;
    $display("clock enable test done");
  endtask
  task automatic t_pull;
    bus(1, `GP_ADDR_ICR2, 8'h80);
    bus(1, 12'h064, 8'he0);
    settle;
    chk(pin_pu[15:8], 8'hff);
    chk(pin_pu[31:24] & pin_pu[39:32] & pin_pu[71:64], 8'hff);
    bus(1, `GP_ADDR_ICR2, 8'h00);
    settle;
    chk(pin_pu[15:8], 8'h00);
    $display("pull-up test done");
  endtask
  task automatic t_od;
    bus(1, 12'h060, 8'h3f);
    bus(1, 12'h020, 8'h00);
    bus(1, 12'h028, 8'h40);
    ext_pu[22] <= 1'b1;
    settle;
    chk(8'({pin_oe_n[23:22], pin_out[23]}), 8'h02);
    bus(0, 12'h024, 8'h00);
    chk(q, 8'h40);
    bus(1, 12'h060, 8'h1f);
    settle;
    chk(8'({pin_oe_n[22], pin_out[22]}), 8'h01);
    $display("open-drain test done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_out;
    t_periph;
    t_ce;
    t_pull;
    t_od;
    stop_test;
  end
endmodule
`default_nettype wire
